/* design/dsbc_map.svh */
/*
  Offsets, field positions, reset values and counts of the strobe and
  data ball block. Definitions only; included by package and top.
*/
`ifndef DSBC_MAP_SVH
`define DSBC_MAP_SVH

// register byte offsets on the register bus
`define DSBC_REG_RDDATA    8'h00
`define DSBC_REG_STATUS    8'h04
`define DSBC_REG_WRDATA    8'h08
`define DSBC_REG_WRCOUNT   8'h0C

// extended mode register fields on the address inputs
`define DSBC_BA_EMR           3'h1
`define DSBC_EMR_DIFF_DIS_BIT 10
`define DSBC_EMR_RDQS_EN_BIT  11

// reset values
`define DSBC_RST_DIFF_DIS  1'b0
`define DSBC_RST_RDQS_EN   1'b0
`define DSBC_RST_RDDATA    16'h0000

// command codes as {csN, rasN, casN, weN}
`define DSBC_CMD_LMR       4'h0
`define DSBC_CMD_READ      4'h5
`define DSBC_CMD_WRITE     4'h4

// burst and bus answer codes
`define DSBC_BURST_LEN     4
`define DSBC_RESP_OKAY     2'h0
`define DSBC_RESP_SLVERR   2'h2

`endif

/* design/dsbc_pkg.sv */
/*
  Types and the command decoder of the strobe and data ball block.
  Assumes the constants header is on the include path.
*/
`include "dsbc_map.svh"

package dsbc_pkg;

  // link sequencer states, one-hot
  typedef enum logic [2:0] {
    DSBC_IDLE  = 3'b001,
    DSBC_READ  = 3'b010,
    DSBC_WRITE = 3'b100
  } dsbc_state_t;

  // decoded commands this block cares about
  typedef enum logic [1:0] {
    CMD_NOP   = 2'h0,
    CMD_LMR   = 2'h1,
    CMD_READ  = 2'h2,
    CMD_WRITE = 2'h3
  } dsbc_cmd_t;

  // all four command inputs take part; chip select high masks all
  function automatic dsbc_cmd_t dsbcDecode(input logic [3:0] pins);
    dsbc_cmd_t c;
    c = CMD_NOP;
    if (pins == `DSBC_CMD_LMR) c = CMD_LMR;
    else if (pins == `DSBC_CMD_READ) c = CMD_READ;
    else if (pins == `DSBC_CMD_WRITE) c = CMD_WRITE;
    return c;
  endfunction

endpackage

/* design/dsbc_strobe_data.sv */
/*
  Data path balls of a DDR2 memory: command decode, data bus, byte
  strobes, complementary strobes and the x8 redundant strobe or mask.
  Link logic runs on the memory clock; software reaches a read word,
  the last written word and the strobe configuration over AXI4-Lite.
  Assumes the pad ring resolves the pin enables into wires.
*/
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
// Contract
// - command decoded from cs, ras, cas, we
// - data bus sixteen or eight bits wide
// - read strobe driven, edge-aligned with data
// - complementary strobe only in differential mode
// - x16 uses lower and upper strobe pairs
// - redundant strobe x8 only, set by EMR
// - redundant strobe driven on reads, ignored on writes
// - redundant strobe disabled means write mask input
// - complementary redundant strobe needs both modes enabled
// - disable bit zero enables complementary strobe balls
// - masked write beat is discarded
// - bank address selects mode register on load
`include "dsbc_map.svh"

module dsbc_strobe_data
  import dsbc_pkg::*;
#(
  parameter int WIDE16    = 1,
  parameter int BURST_LEN = `DSBC_BURST_LEN,
  parameter int ADDR_W    = 14
) (
  // core clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // register bus, write side
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // register bus, read side
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // link clock and command balls
  input  wire logic              linkClk,
  input  wire logic              csN,
  input  wire logic              rasN,
  input  wire logic              casN,
  input  wire logic              weN,
  input  wire logic [2:0]        ba,
  input  wire logic [ADDR_W-1:0] addr,
  // data balls
  input  wire logic [15:0]       dqIn,
  output logic [15:0]            dqOut,
  output logic [15:0]            dqOe,
  input  wire logic              ldm,
  input  wire logic              udm,
  // lower and upper byte strobes
  input  wire logic              ldqsIn,
  output logic                   ldqsOut,
  output logic                   ldqsOe,
  output logic                   ldqsNOut,
  output logic                   ldqsNOe,
  input  wire logic              udqsIn,
  output logic                   udqsOut,
  output logic                   udqsOe,
  output logic                   udqsNOut,
  output logic                   udqsNOe,
  // redundant strobe ball, mask input when disabled
  input  wire logic              rdqsIn,
  output logic                   rdqsOut,
  output logic                   rdqsOe,
  output logic                   rdqsNOut,
  output logic                   rdqsNOe
);

  localparam int BEAT_W = (BURST_LEN > 2) ? $clog2(BURST_LEN) : 1;
  localparam int CNT_W  = $clog2(BURST_LEN + 1);
  localparam logic [BEAT_W-1:0] BEAT_LAST = BEAT_W'(BURST_LEN - 1);

  logic linkRst1_q, linkReset;
  logic [15:0] dqOut_q;
  dsbc_state_t state_q, state_d;
  dsbc_cmd_t cmdNow;
  logic [BEAT_W-1:0] beat_q, beat_d;
  logic diffDis_q, diffDis_d, rdqsEn_q, rdqsEn_d;
  logic [15:0] dqOut_d, wrWord_q, wrWord_d, rdWordL;
  logic dqsOut_q, dqsOut_d, lastBeat, reading, wrSend;
  logic [CNT_W-1:0] kept_q, kept_d;
  logic [1:0] mask, stSent_q, stSent_d;
  logic stSend, stBusy, wrBusy, dmX8;
  logic rdBusy, rdSend, rdValidL;
  logic [15:0] rdData_q, rdData_d, rdSent_q, rdSent_d;
  logic [15:0] wrData_q, wrData_d, wrCount_q, wrCount_d;
  logic [1:0] stCore, stCore_q, stCore_d;
  logic stValid, wrValid;
  logic [CNT_W+15:0] wrXfer;
  logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
  logic [7:0] awAddr_q, awAddr_d;
  logic [31:0] wData_q, wData_d, rdata_d;
  logic [3:0] wStrb_q, wStrb_d;
  logic bvalid_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;

  // reset reaches the link domain as a level through two flops
  always_ff @(posedge linkClk) begin
    linkRst1_q <= reset;
    linkReset  <= linkRst1_q;
  end

  // link sequencer: commands, bursts, mode register load
  always_comb begin
    cmdNow    = dsbcDecode({csN, rasN, casN, weN});
    state_d   = state_q;
    beat_d    = beat_q;
    diffDis_d = diffDis_q;
    rdqsEn_d  = rdqsEn_q;
    dqOut_d   = dqOut_q;
    dqsOut_d  = dqsOut_q;
    wrWord_d  = wrWord_q;
    kept_d    = kept_q;
    wrSend    = 1'b0;
    lastBeat  = beat_q == BEAT_LAST;
    dmX8      = rdqsEn_q ? 1'b0 : rdqsIn;
    mask      = (WIDE16 != 0) ? {udm, ldm} : {1'b1, dmX8};
    case (state_q)
      DSBC_IDLE: begin
        beat_d = '0;
        if (cmdNow == CMD_READ) begin
          state_d  = DSBC_READ;
          dqOut_d  = rdWordL;
          dqsOut_d = 1'b1;
        end else if (cmdNow == CMD_WRITE) begin
          state_d = DSBC_WRITE;
          kept_d  = '0;
        end else if (cmdNow == CMD_LMR && ba == `DSBC_BA_EMR) begin
          diffDis_d = addr[`DSBC_EMR_DIFF_DIS_BIT];
          rdqsEn_d  = (WIDE16 == 0) && addr[`DSBC_EMR_RDQS_EN_BIT];
        end
      end
      DSBC_READ: begin
        beat_d   = beat_q + 1'b1;
        dqOut_d  = rdWordL ^ {{(16-BEAT_W){1'b0}}, beat_d};
        dqsOut_d = ~dqsOut_q;
        if (lastBeat) begin
          state_d = DSBC_IDLE;
        end
      end
      DSBC_WRITE: begin
        // beats sampled on the link edge, centred by the controller
        beat_d = beat_q + 1'b1;
        if (!(&mask)) begin
          if (!mask[0]) wrWord_d[7:0] = dqIn[7:0];
          if (!mask[1]) wrWord_d[15:8] = dqIn[15:8];
          kept_d = kept_q + 1'b1;
        end
        if (lastBeat) begin
          state_d = DSBC_IDLE;
          wrSend  = 1'b1; // dropped if a crossing is still busy
        end
      end
      default: state_d = DSBC_IDLE;
    endcase
    stSend   = (stSent_q != {diffDis_q, rdqsEn_q}) && !stBusy;
    stSent_d = stSend ? {diffDis_q, rdqsEn_q} : stSent_q;
  end

  always_ff @(posedge linkClk) begin
    if (linkReset) begin
      state_q   <= DSBC_IDLE;
      beat_q    <= '0;
      diffDis_q <= `DSBC_RST_DIFF_DIS;
      rdqsEn_q  <= `DSBC_RST_RDQS_EN;
      dqOut_q   <= 16'h0000;
      dqsOut_q  <= 1'b0;
      wrWord_q  <= 16'h0000;
      kept_q    <= '0;
      stSent_q  <= {`DSBC_RST_DIFF_DIS, `DSBC_RST_RDQS_EN};
    end else begin
      state_q   <= state_d;
      beat_q    <= beat_d;
      diffDis_q <= diffDis_d;
      rdqsEn_q  <= rdqsEn_d;
      dqOut_q   <= dqOut_d;
      dqsOut_q  <= dqsOut_d;
      wrWord_q  <= wrWord_d;
      kept_q    <= kept_d;
      stSent_q  <= stSent_d;
    end
  end


  // pin drive: enables only during a read burst
  always_comb begin
    reading  = state_q == DSBC_READ;
    dqOut    = dqOut_q;
    dqOe     = {{8{reading && WIDE16 != 0}}, {8{reading}}};
    ldqsOut  = dqsOut_q;
    ldqsOe   = reading;
    udqsOut  = dqsOut_q;
    udqsOe   = reading && WIDE16 != 0;
    ldqsNOut = ~dqsOut_q;
    ldqsNOe  = ldqsOe && !diffDis_q;
    udqsNOut = ~dqsOut_q;
    udqsNOe  = udqsOe && !diffDis_q;
    rdqsOut  = dqsOut_q;
    rdqsOe   = reading && rdqsEn_q;
    rdqsNOut = ~dqsOut_q;
    rdqsNOe  = rdqsOe && !diffDis_q;
  end

  // crossings: read word in, written word and configuration out
  dsbc_word_sync #(.W(16)) rdSync (
    .srcClk(core_clk), .srcReset(reset), .srcSend(rdSend),
    .srcData(rdData_q), .srcBusy(rdBusy), .dstClk(linkClk),
    .dstReset(linkReset), .dstValid(rdValidL), .dstData(rdWordL));
  dsbc_word_sync #(.W(CNT_W + 16)) wrSync (
    .srcClk(linkClk), .srcReset(linkReset), .srcSend(wrSend),
    .srcData({kept_d, wrWord_d}), .srcBusy(wrBusy), .dstClk(core_clk),
    .dstReset(reset), .dstValid(wrValid), .dstData(wrXfer));
  dsbc_word_sync #(.W(2)) stSync (
    .srcClk(linkClk), .srcReset(linkReset), .srcSend(stSend),
    .srcData({diffDis_q, rdqsEn_q}), .srcBusy(stBusy),
    .dstClk(core_clk), .dstReset(reset), .dstValid(stValid),
    .dstData(stCore));

  // register bus slave and core registers
  always_comb begin
    awready  = !awHeld_q && !bvalid;
    wready   = !wHeld_q && !bvalid;
    arready  = !rvalid;
    awHeld_d = awHeld_q || (awvalid && awready);
    awAddr_d = (awvalid && awready) ? awaddr : awAddr_q;
    wHeld_d  = wHeld_q || (wvalid && wready);
    wData_d  = (wvalid && wready) ? wdata : wData_q;
    wStrb_d  = (wvalid && wready) ? wstrb : wStrb_q;
    bvalid_d = bvalid && !bready;
    bresp_d  = bresp;
    rdData_d = rdData_q;
    if (awHeld_q && wHeld_q) begin
      awHeld_d = 1'b0;
      wHeld_d  = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = `DSBC_RESP_OKAY;
      if (awAddr_q[7:2] == `DSBC_REG_RDDATA >> 2) begin
        if (wStrb_q[0]) rdData_d[7:0] = wData_q[7:0];
        if (wStrb_q[1]) rdData_d[15:8] = wData_q[15:8];
      end else if (awAddr_q[7:2] == `DSBC_REG_STATUS >> 2) begin
        bresp_d = `DSBC_RESP_OKAY;
      end else if (awAddr_q[7:2] == `DSBC_REG_WRDATA >> 2) begin
        bresp_d = `DSBC_RESP_OKAY;
      end else if (awAddr_q[7:2] == `DSBC_REG_WRCOUNT >> 2) begin
        bresp_d = `DSBC_RESP_OKAY;
      end else begin
        bresp_d = `DSBC_RESP_SLVERR;
      end
    end
    rvalid_d = rvalid && !rready;
    rdata_d  = rdata;
    rresp_d  = rresp;
    if (arvalid && arready) begin
      rvalid_d = 1'b1;
      rresp_d  = `DSBC_RESP_OKAY;
      if (araddr[7:2] == `DSBC_REG_RDDATA >> 2) begin
        rdata_d = {16'h0000, rdData_q};
      end else if (araddr[7:2] == `DSBC_REG_STATUS >> 2) begin
        rdata_d = {28'h0000000, rdBusy, WIDE16 != 0, stCore_q};
      end else if (araddr[7:2] == `DSBC_REG_WRDATA >> 2) begin
        rdata_d = {16'h0000, wrData_q};
      end else if (araddr[7:2] == `DSBC_REG_WRCOUNT >> 2) begin
        rdata_d = {16'h0000, wrCount_q};
      end else begin
        rdata_d = 32'h00000000;
        rresp_d = `DSBC_RESP_SLVERR;
      end
    end
    // new read word goes over once the crossing is free and it differs from the last sent
    rdSend    = (rdSent_q != rdData_q) && !rdBusy;
    rdSent_d  = rdSend ? rdData_q : rdSent_q;
    wrData_d  = wrValid ? wrXfer[15:0] : wrData_q;
    wrCount_d = wrValid ? wrCount_q + 16'(wrXfer[CNT_W+15:16])
                        : wrCount_q;
    stCore_d  = stValid ? stCore : stCore_q;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      awHeld_q  <= 1'b0;
      awAddr_q  <= 8'h00;
      wHeld_q   <= 1'b0;
      wData_q   <= 32'h00000000;
      wStrb_q   <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= `DSBC_RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= 32'h00000000;
      rresp     <= `DSBC_RESP_OKAY;
      rdData_q  <= `DSBC_RST_RDDATA;
      rdSent_q  <= `DSBC_RST_RDDATA;
      wrData_q  <= 16'h0000;
      wrCount_q <= 16'h0000;
      stCore_q  <= {`DSBC_RST_DIFF_DIS, `DSBC_RST_RDQS_EN};
    end else begin
      awHeld_q  <= awHeld_d;
      awAddr_q  <= awAddr_d;
      wHeld_q   <= wHeld_d;
      wData_q   <= wData_d;
      wStrb_q   <= wStrb_d;
      bvalid    <= bvalid_d;
      bresp     <= bresp_d;
      rvalid    <= rvalid_d;
      rdata     <= rdata_d;
      rresp     <= rresp_d;
      rdData_q  <= rdData_d;
      rdSent_q  <= rdSent_d;
      wrData_q  <= wrData_d;
      wrCount_q <= wrCount_d;
      stCore_q  <= stCore_d;
    end
  end

  // checks on the link side, and one on the register bus side
  cmd_read_a: assert property (@(posedge linkClk) disable iff (linkReset)
    state_q == DSBC_IDLE && {csN, rasN, casN, weN} == `DSBC_CMD_READ
    |=> state_q == DSBC_READ) else $error("read command not taken");
  dq_width_a: assert property (@(posedge linkClk) disable iff (linkReset)
    WIDE16 == 0 |-> dqOe[15:8] == 8'h00) else $error("upper byte driven");
  read_edge_a: assert property (@(posedge linkClk) disable iff (linkReset)
    reading && $past(reading) |-> ldqsOut != $past(ldqsOut) && dqOe[0])
    else $error("read strobe not toggling with data");
  diff_gate_a: assert property (@(posedge linkClk) disable iff (linkReset)
    ldqsNOe |-> !diffDis_q && ldqsOe) else $error("dqs pair misused");
  upper_pair_a: assert property (@(posedge linkClk) disable iff (linkReset)
    WIDE16 != 0 |-> udqsOe == ldqsOe && udqsNOe == ldqsNOe)
    else $error("strobe pairs disagree");
  rdqs_org_a: assert property (@(posedge linkClk) disable iff (linkReset)
    WIDE16 != 0 |-> !rdqsOe && !rdqsEn_q) else $error("rdqs in x16");
  rdqs_write_a: assert property (@(posedge linkClk) disable iff (linkReset)
    state_q == DSBC_WRITE |-> !rdqsOe && !rdqsNOe)
    else $error("rdqs driven on write");
  rdqsn_gate_a: assert property (@(posedge linkClk) disable iff (linkReset)
    rdqsNOe |-> rdqsEn_q && !diffDis_q) else $error("rdqs# misused");
  emr_load_a: assert property (@(posedge linkClk) disable iff (linkReset)
    state_q == DSBC_IDLE && {csN, rasN, casN, weN} == `DSBC_CMD_LMR
    && ba == `DSBC_BA_EMR
    |=> diffDis_q == $past(addr[`DSBC_EMR_DIFF_DIS_BIT]))
    else $error("emr load lost");
  mask_drop_a: assert property (@(posedge linkClk) disable iff (linkReset)
    state_q == DSBC_WRITE && (&mask) |=> kept_q == $past(kept_q))
    else $error("masked beat kept");
  burst_len_a: assert property (@(posedge linkClk) disable iff (linkReset)
    $rose(reading) |-> reading[*4] ##1 (dqOe == 16'h0000 && !ldqsOe))
    else $error("read burst length wrong");
  axi_resp_a: assert property (@(posedge core_clk) disable iff (reset)
    awHeld_q && wHeld_q |=> bvalid) else $error("write answer late");
  read_cov: cover property (@(posedge linkClk) disable iff (linkReset)
    $rose(reading) && ldqsNOe);
  write_cov: cover property (@(posedge linkClk) disable iff (linkReset)
    wrSend && !wrBusy);
  rdqs_cov: cover property (@(posedge linkClk) disable iff (linkReset)
    rdqsNOe);

endmodule

/* design/dsbc_word_sync.sv */
/*
  Toggle handshake that carries one word from one clock domain to
  another. Source holds the word while busy; sends while busy are
  dropped, so the caller checks busy first.
*/
module dsbc_word_sync
  import dsbc_pkg::*;
#(
  parameter int W = 8
) (
  // source domain
  input  wire logic         srcClk,
  input  wire logic         srcReset,
  input  wire logic         srcSend,
  input  wire logic [W-1:0] srcData,
  output logic              srcBusy,
  // destination domain
  input  wire logic         dstClk,
  input  wire logic         dstReset,
  output logic              dstValid,
  output logic [W-1:0]      dstData
);

  logic         reqT_q, reqT_d, ackS1_q, ackS2_q;
  logic [W-1:0] hold_q, hold_d;
  logic         reqS1_q, reqS2_q, reqS3_q;
  logic         valid_d;
  logic [W-1:0] data_d;

  // source: toggle the request and freeze the word until acked
  always_comb begin
    srcBusy = reqT_q != ackS2_q;
    reqT_d  = reqT_q;
    hold_d  = hold_q;
    if (srcSend && !srcBusy) begin
      reqT_d = ~reqT_q;
      hold_d = srcData;
    end
  end

  always_ff @(posedge srcClk) begin
    if (srcReset) begin
      reqT_q  <= 1'b0;
      hold_q  <= '0;
      ackS1_q <= 1'b0;
      ackS2_q <= 1'b0;
    end else begin
      reqT_q  <= reqT_d;
      hold_q  <= hold_d;
      ackS1_q <= reqS3_q;
      ackS2_q <= ackS1_q;
    end
  end

  // destination: a change between the second and third stages marks a new word
  always_comb begin
    valid_d = reqS2_q != reqS3_q;
    data_d  = valid_d ? hold_q : dstData;
  end

  always_ff @(posedge dstClk) begin
    if (dstReset) begin
      reqS1_q  <= 1'b0;
      reqS2_q  <= 1'b0;
      reqS3_q  <= 1'b0;
      dstValid <= 1'b0;
      dstData  <= '0;
    end else begin
      reqS1_q  <= reqT_q;
      reqS2_q  <= reqS1_q;
      reqS3_q  <= reqS2_q;
      dstValid <= valid_d;
      dstData  <= data_d;
    end
  end

endmodule

/* sim/dsbc_ctrl_model.sv */
/*
  Memory controller model facing the strobe and data balls: commands,
  write beats with byte masks and centred write strobes.
  Assumes the bench supplies the memory clock.
*/
`include "dsbc_map.svh"

module dsbc_ctrl_model
  import dsbc_pkg::*;
(
  // memory clock
  input  wire logic   linkClk,
  // command and address balls
  output logic        csN,
  output logic        rasN,
  output logic        casN,
  output logic        weN,
  output logic [2:0]  ba,
  output logic [13:0] addr,
  // write data, masks and strobes
  output logic [15:0] dqIn,
  output logic        ldm,
  output logic        udm,
  output logic        ldqsIn,
  output logic        udqsIn,
  output logic        rdqsIn
);
  timeunit 1ns;
  timeprecision 1ps;

  logic strobeOn;

  // deselected and quiet from time zero
  initial begin
    {ba, addr, dqIn, ldm, udm, rdqsIn} = '0;
    {csN, rasN, casN, weN, strobeOn, ldqsIn, udqsIn} = 7'h78;
  end

  // strobe edges mid-beat, so they sit in the data eye
  always @(negedge linkClk) begin
    if (strobeOn) begin
      ldqsIn <= ~ldqsIn;
      udqsIn <= ~udqsIn;
    end
  end

  // one command; afterwards deselect and scramble the address
  task automatic issue(input logic [3:0] c, input logic [2:0] b,
                       input logic [13:0] a);
    @(posedge linkClk);
    {csN, rasN, casN, weN} <= c;
    ba <= b;
    addr <= {1'b0, a[12:0]};
    @(posedge linkClk);
    {csN, rasN, casN, weN} <= 4'hF;
    ba <= ~b;
    addr <= {1'b0, ~a[12:0]};
  endtask

  // write burst, masks as {udm, ldm}; bus garbled once released
  task automatic writeBurst(input logic [15:0] d [`DSBC_BURST_LEN],
                            input logic [1:0] m [`DSBC_BURST_LEN]);
    issue(`DSBC_CMD_WRITE, 3'h0, 14'h0000);
    strobeOn <= 1'b1;
    for (int i = 0; i < `DSBC_BURST_LEN; i++) begin
      dqIn <= d[i];
      {udm, ldm} <= m[i];
      rdqsIn <= m[i][0];
      @(posedge linkClk);
    end
    dqIn <= ~d[`DSBC_BURST_LEN-1];
    {udm, ldm} <= ~m[`DSBC_BURST_LEN-1];
    strobeOn <= 1'b0;
  endtask
endmodule

/* sim/dsbc_strobe_data_tb.sv */
/*
  Self-checking bench of the strobe and data balls, x16 build.
  Assumes the controller model and the design files are compiled.
*/
`include "dsbc_map.svh"

module dsbc_strobe_data_tb
  import dsbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        core_clk = 1'b0;
  logic        reset;
  logic        linkClk;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        csN, rasN, casN, weN, ldm, udm, ldqsIn, udqsIn, rdqsIn;
  logic [2:0]  ba;
  logic [13:0] addr;
  logic [15:0] dqIn, dqOut, dqOe;
  logic        ldqsOut, ldqsOe, ldqsNOut, ldqsNOe, rdqsOut, rdqsOe;
  logic        udqsOut, udqsOe, udqsNOut, udqsNOe, rdqsNOut, rdqsNOe;
  int          failures = 0;
  int          checksDone = 0;

  // core clock 250 MHz
  always #2 core_clk = ~core_clk;

  // memory clock 80 ns; odd offset keeps edges apart from the core
  initial begin
    linkClk = 1'b0;
    #13;
    forever #40 linkClk = ~linkClk;
  end

  dsbc_ctrl_model i_ctrl (.linkClk(linkClk), .csN(csN), .rasN(rasN),
    .casN(casN), .weN(weN), .ba(ba), .addr(addr), .dqIn(dqIn),
    .ldm(ldm), .udm(udm), .ldqsIn(ldqsIn), .udqsIn(udqsIn),
    .rdqsIn(rdqsIn));

  dsbc_strobe_data #(.WIDE16(1), .BURST_LEN(`DSBC_BURST_LEN),
    .ADDR_W(14)) i_dut (.core_clk(core_clk), .reset(reset),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .linkClk(linkClk), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .ba(ba), .addr(addr), .dqIn(dqIn), .dqOut(dqOut),
    .dqOe(dqOe), .ldm(ldm), .udm(udm), .ldqsIn(ldqsIn),
    .ldqsOut(ldqsOut), .ldqsOe(ldqsOe), .ldqsNOut(ldqsNOut),
    .ldqsNOe(ldqsNOe), .udqsIn(udqsIn), .udqsOut(udqsOut),
    .udqsOe(udqsOe), .udqsNOut(udqsNOut), .udqsNOe(udqsNOe),
    .rdqsIn(rdqsIn), .rdqsOut(rdqsOut), .rdqsOe(rdqsOe),
    .rdqsNOut(rdqsNOut), .rdqsNOe(rdqsNOe));

  task automatic cmpVal(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
    cmpVal({30'h0, got}, {30'h0, exp});
  endtask

  task automatic final_report;
    $display("checks %0d, mismatches %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // write: address and data offered together, each released when taken
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge core_clk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 200);
    r = bresp;
    bready <= 1'b0;
    if (n >= 200) failures++;
  endtask

  task automatic axiRd(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
    int n;
    n = 0;
    @(posedge core_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge core_clk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 200);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 200) failures++;
  endtask

  task automatic regChk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axiRd(a, d, r);
    cmpVal(d, e);
    cmpResp(r, er);
  endtask

  // reset values, byte lanes, read-only and unmapped places
  task automatic tRegs;
    logic [1:0] r;
    regChk(`DSBC_REG_STATUS, 32'h0000_0004, `DSBC_RESP_OKAY);
    regChk(`DSBC_REG_RDDATA, 32'h0000_0000, `DSBC_RESP_OKAY);
    axiWr(`DSBC_REG_RDDATA, 32'h1234_A5C3, 4'hF, r);
    cmpResp(r, `DSBC_RESP_OKAY);
    axiWr(`DSBC_REG_RDDATA, 32'h0000_7700, 4'h2, r);
    regChk(`DSBC_REG_RDDATA, 32'h0000_77C3, `DSBC_RESP_OKAY);
    axiWr(`DSBC_REG_STATUS, 32'hFFFF_FFFF, 4'hF, r);
    cmpResp(r, `DSBC_RESP_OKAY);
    // the new read word needs several memory cycles to cross: busy set
    regChk(`DSBC_REG_STATUS, 32'h0000_000C, `DSBC_RESP_OKAY);
    axiWr(8'h10, 32'hFFFF_FFFF, 4'hF, r);
    cmpResp(r, `DSBC_RESP_SLVERR);
    regChk(8'h10, 32'h0000_0000, `DSBC_RESP_SLVERR);
    // both words have crossed before the first link read starts
    repeat (10) @(posedge linkClk);
    regChk(`DSBC_REG_STATUS, 32'h0000_0004, `DSBC_RESP_OKAY);
  endtask

  // read burst: beats, strobe pattern, then data and byte strobe balls released
  task automatic tRead(input logic [15:0] w, input logic diff);
    repeat (4) @(posedge linkClk);
    i_ctrl.issue(`DSBC_CMD_READ, 3'h0, 14'h0040);
    for (int i = 0; i < `DSBC_BURST_LEN; i++) begin
      @(negedge linkClk);
      cmpVal(32'({dqOe, ldqsOe, udqsOe, rdqsOe}), 32'h0007_FFFE);
      cmpVal(32'(dqOut), 32'(w ^ 16'(i)));
      cmpVal(32'({ldqsOut, udqsOut, ldqsNOe, udqsNOe}),
             32'({~i[0], ~i[0], diff, diff}));
      if (diff)
        cmpVal(32'({ldqsNOut, udqsNOut}), 32'({i[0], i[0]}));
      @(posedge linkClk);
    end
    @(negedge linkClk);
    cmpVal(32'({dqOe, ldqsOe, udqsOe, ldqsNOe, udqsNOe}), 32'h0);
  endtask

  // write burst with one beat fully masked and one byte masked
  task automatic tWrite;
    logic [15:0] d [`DSBC_BURST_LEN];
    logic [1:0]  m [`DSBC_BURST_LEN];
    logic [31:0] c0;
    logic [1:0]  r;
    d = '{16'h1122, 16'h3344, 16'h5566, 16'h7788};
    m = '{2'h0, 2'h3, 2'h0, 2'h1};
    axiRd(`DSBC_REG_WRCOUNT, c0, r);
    i_ctrl.writeBurst(d, m);
    repeat (4) @(posedge linkClk);
    regChk(`DSBC_REG_WRDATA, 32'h0000_7766, `DSBC_RESP_OKAY);
    regChk(`DSBC_REG_WRCOUNT, 32'(16'(c0 + 3)), `DSBC_RESP_OKAY);
  endtask

  // chip select high or unknown codes must never drive the data or strobe balls
  task automatic tDeselect;
    logic [3:0] codes [3];
    codes = '{4'hD, 4'hC, 4'h1};
    foreach (codes[k]) begin
      i_ctrl.issue(codes[k], 3'h0, 14'h0000);
      repeat (3) begin
        @(posedge linkClk);
        @(negedge linkClk);
        cmpVal(32'({dqOe, ldqsOe, udqsOe}), 32'h0);
      end
    end
  endtask

  // mode loads: disable bit, wrong register, redundant enable in x16
  task automatic tModes;
    i_ctrl.issue(`DSBC_CMD_LMR, `DSBC_BA_EMR, 14'h0400);
    repeat (4) @(posedge linkClk);
    regChk(`DSBC_REG_STATUS, 32'h0000_0006, `DSBC_RESP_OKAY);
    tRead(16'h77C3, 1'b0);
    i_ctrl.issue(`DSBC_CMD_LMR, 3'h0, 14'h0000);
    repeat (4) @(posedge linkClk);
    regChk(`DSBC_REG_STATUS, 32'h0000_0006, `DSBC_RESP_OKAY);
    i_ctrl.issue(`DSBC_CMD_LMR, `DSBC_BA_EMR, 14'h0800);
    tRead(16'h77C3, 1'b1);
  endtask

  // reset spans three memory edges so the link side sees it too
  initial begin
    reset = 1'b1;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    repeat (3) @(posedge linkClk);
    @(posedge core_clk);
    reset <= 1'b0;
    repeat (3) @(posedge linkClk);
    tRegs;
    tRead(16'h77C3, 1'b1);
    tWrite;
    tDeselect;
    tModes;
    final_report;
  end

  // watchdog: the whole run needs well under a fifth of this
  initial begin
    repeat (40000) @(posedge core_clk);
    failures++;
    final_report;
  end
endmodule
